// >>> scli_pkg.sv
// Constants and types shared by the serial command line interpreter
package scli_pkg;

  // ------------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ANID = 8'h04;
  localparam logic [7:0] REG_TIME = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0C;
  localparam logic [7:0] REG_CMD = 8'h10;
  localparam logic [7:0] REG_ARGS = 8'h14;
  localparam logic [7:0] REG_MSGD = 8'h18;
  localparam logic [7:0] REG_MSGC = 8'h1C;

  // ------------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------------
  localparam int CTRL_QUIET = 0;
  localparam int CTRL_FLAG1 = 1;
  localparam int CTRL_FLAG2 = 2;
  localparam int STAT_TERM = 0;
  localparam int STAT_CMD = 1;
  localparam int STAT_ERR = 2;
  localparam int STAT_DROP = 3;
  localparam int STAT_BUSY = 4;
  localparam int STAT_VALID = 5;
  localparam int STAT_LEN = 8;
  localparam int TIME_MIN = 0;
  localparam int TIME_HOUR = 8;
  localparam int TIME_DAY = 16;
  localparam int MSGC_UNSOL = 8;
  localparam logic [13:0] ANID_RESET = 14'h0000;
  localparam logic [8:0] DAY_RESET = 9'h001;

  // ------------------------------------------------------------------
  // Character codes
  // ------------------------------------------------------------------
  localparam logic [7:0] CH_CTRL_C = 8'h03;
  localparam logic [7:0] CH_BS = 8'h08;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_CTRL_P = 8'h10;
  localparam logic [7:0] CH_CTRL_T = 8'h14;
  localparam logic [7:0] CH_ESC = 8'h1B;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_QUOTE = 8'h22;
  localparam logic [7:0] CH_COLON = 8'h3A;
  localparam logic [7:0] CH_QMARK = 8'h3F;
  localparam logic [7:0] CH_BAR = 8'h7C;

  // ------------------------------------------------------------------
  // Argument classes and help listing
  // ------------------------------------------------------------------
  localparam logic [2:0] CLS_NONE = 3'h0;
  localparam logic [2:0] CLS_INT = 3'h1;
  localparam logic [2:0] CLS_HEX = 3'h2;
  localparam logic [2:0] CLS_FLOAT = 3'h3;
  localparam logic [2:0] CLS_BOOL = 3'h4;
  localparam logic [2:0] CLS_STR = 3'h5;
  localparam logic [2:0] CLS_WORD = 3'h6;
  localparam logic [2:0] CLS_BAD = 3'h7;
  localparam int HELP_LEN = 82;
  localparam logic [8*HELP_LEN-1:0] HELP_TEXT =
    "C CALIBRATION|D DIAGNOSTIC|L LOGON|T TEST MEASUREMENT|V VARIABLE|W WARNING|? HELP|";
  localparam logic [4:0] HEAD_LAST = 5'h10;

  // Per-token scan flags
  typedef struct packed {
    logic [7:0] len;
    logic quote;
    logic closed;
    logic bad;
    logic digits;
    logic [1:0] dots;
    logic numok;
    logic hexok;
    logic [23:0] word;
    logic [13:0] val;
  } scli_tok_t;

  typedef enum logic [1:0] {SC_IDLE = 2'b00, SC_SCAN = 2'b01, SC_DONE = 2'b11} scli_scan_t;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000, TX_HEAD = 3'b001, TX_BODY = 3'b011, TX_CR = 3'b010,
    TX_LF = 3'b110, TX_HELP = 3'b111
  } scli_tx_t;

endpackage : scli_pkg

// >>> scli_core.sv
// Serial command line interpreter: line editing, parsing and message formatting
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/10ps

// Notes on behaviour
// [R1] Control-T selects terminal mode: echo on, line editing on.
// [R2] Control-C selects computer mode: no echo, no editing.
// [R3] Terminal mode is entered only while mode flags 1 and 2 are off.
// [R4] Characters are buffered; nothing executes before a carriage return.
// [R5] Backspace while editing removes the last buffered character.
// [R6] Escape throws away the whole partial line.
// [R7] A question mark line, optional matching id, prints the command list.
// [R8] Control-P restarts the command listing from the start.
// [R9] Keywords match in any case; arguments are split by spaces.
// [R10] Line is type letter, optional id, command and arguments, then CR.
// [R11] Type letters C, D, L, T, V, W are the only valid ones.
// [R12] Integer: optional sign then one or more decimal digits.
// [R13] Hex integer: 0x then one or more hex digits, never signed.
// [R14] Float: optional sign, digits, optional point; one digit needed, no exponent.
// [R15] Booleans are only the keywords ON and OFF.
// [R16] String: quote, printable characters, closing quote; a quote always ends it.
// [R17] Names are taken only in full, never expanded from abbreviations.
// [R18] Unsolicited status messages are dropped while quiet mode is set.
// [R19] Each message opens with type letter and day:hour:minute stamp.
// [R20] The analyzer id, one to four digits, follows the stamp, then content.
// [R21] The message letter uses the same encoding as command types.
// [R22] Each message ends in carriage return then line feed.
// [R23] Day has three digits, hour and minute two, zero padded.
module scli_core #(
  parameter int LINE_DEPTH = 64,
  parameter int MSG_DEPTH = 32,
  parameter int MAX_TOK = 8
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready
);
  import scli_pkg::*;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [7:0] upc(input logic [7:0] c);
    return (c >= 8'h61 && c <= 8'h7A) ? (c - 8'h20) : c;
  endfunction : upc

  function automatic logic is_dig(input logic [7:0] c);
    return c >= 8'h30 && c <= 8'h39;
  endfunction : is_dig

  function automatic logic is_type(input logic [7:0] c);
    return c == "C" || c == "D" || c == "L" || c == "T" || c == "V" || c == "W";
  endfunction : is_type

  function automatic logic [7:0] dec_ch(input logic [13:0] v, input logic [13:0] place);
    return 8'h30 + 8'((v / place) % 14'd10);
  endfunction : dec_ch

  function automatic logic [2:0] classify(input scli_tok_t t);
    logic [2:0] c;
    c = CLS_WORD;
    if (t.quote) begin
      c = (t.closed && !t.bad && t.len >= 8'h03) ? CLS_STR : CLS_BAD; // R16
    end else if (t.hexok && t.len >= 8'h03) begin
      c = CLS_HEX; // R13
    end else if (t.numok && t.digits && t.dots == 2'h0) begin
      c = CLS_INT; // R12
    end else if (t.numok && t.digits && t.dots == 2'h1) begin
      c = CLS_FLOAT; // R14
    end else if ((t.len == 8'h02 && t.word[23:8] == "ON") ||
                 (t.len == 8'h03 && t.word == "OFF")) begin
      c = CLS_BOOL; // R15 R17
    end
    return c;
  endfunction : classify

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic quiet_r, quiet_nxt, flag1_r, flag1_nxt, flag2_r, flag2_nxt;
  logic [13:0] anid_r, anid_nxt;
  logic [8:0] day_r, day_nxt;
  logic [4:0] hour_r, hour_nxt;
  logic [5:0] min_r, min_nxt;
  logic term_r, term_nxt, cmd_r, cmd_nxt, err_r, err_nxt, drop_r, drop_nxt;
  logic valid_r, valid_nxt;
  logic [7:0] type_r, type_nxt;
  logic [3:0] ntok_r, ntok_nxt;
  logic [3*MAX_TOK-1:0] cls_r, cls_nxt;
  logic [7:0] line_r [LINE_DEPTH];
  logic [7:0] line_nxt [LINE_DEPTH];
  logic [7:0] len_r, len_nxt, sidx_r, sidx_nxt;
  logic [7:0] msg_r [MSG_DEPTH];
  logic [7:0] msg_nxt [MSG_DEPTH];
  logic [7:0] mlen_r, mlen_nxt, mtype_r, mtype_nxt;
  logic rx_ready_r, rx_ready_nxt, echo_pend_r, echo_pend_nxt;
  logic [7:0] echo_ch_r, echo_ch_nxt;
  logic help_go_r, help_go_nxt, msg_go_r, msg_go_nxt;
  logic in_quote_r, in_quote_nxt;
  logic [13:0] id_arg_r, id_arg_nxt;
  scli_tok_t tk_r, tk_nxt;
  scli_scan_t sc_r, sc_nxt;
  scli_tx_t tx_r, tx_nxt;
  logic [7:0] tx_data_r, tx_data_nxt, blen_r, blen_nxt, pos_r, pos_nxt;
  logic tx_valid_r, tx_valid_nxt, help_mode_r, help_mode_nxt;
  logic [4:0] hpos_r, hpos_nxt;
  logic echo_take, tx_busy;

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign rx_ready = rx_ready_r;
  assign tx_valid = tx_valid_r;
  assign tx_data = tx_data_r;
  assign tx_busy = tx_r != TX_IDLE;

  // ------------------------------------------------------------------
  // Register file, line editor and parser
  // ------------------------------------------------------------------
  // All command side state; the transmitter reads its pulses, flags, stamp, id and message buffer
  always_comb begin
    logic [7:0] c;
    logic take, wr, hit, tend, delim, help_ok;
    logic [2:0] tcls;
    c = 8'h00;
    tcls = CLS_NONE;
    delim = 1'b0;
    tend = 1'b0;
    help_ok = 1'b0;
    prdata_nxt = prdata_r;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    quiet_nxt = quiet_r;
    flag1_nxt = flag1_r;
    flag2_nxt = flag2_r;
    anid_nxt = anid_r;
    day_nxt = day_r;
    hour_nxt = hour_r;
    min_nxt = min_r;
    term_nxt = term_r;
    cmd_nxt = cmd_r;
    err_nxt = err_r;
    drop_nxt = drop_r;
    valid_nxt = valid_r;
    type_nxt = type_r;
    ntok_nxt = ntok_r;
    cls_nxt = cls_r;
    line_nxt = line_r;
    len_nxt = len_r;
    sidx_nxt = sidx_r;
    msg_nxt = msg_r;
    mlen_nxt = mlen_r;
    mtype_nxt = mtype_r;
    echo_pend_nxt = echo_pend_r && !echo_take;
    echo_ch_nxt = echo_ch_r;
    help_go_nxt = 1'b0;
    msg_go_nxt = 1'b0;
    in_quote_nxt = in_quote_r;
    id_arg_nxt = id_arg_r;
    tk_nxt = tk_r;
    sc_nxt = sc_r;
    hit = paddr[1:0] == 2'b00 && paddr <= REG_MSGC;
    take = rx_valid && rx_ready_r;
    // One wait state: read data is loaded with pready
    if (psel && penable && !pready_r) begin
      pready_nxt = 1'b1;
      pslverr_nxt = !hit;
      case (paddr)
        REG_CTRL: prdata_nxt = {29'h0000_0000, flag2_r, flag1_r, quiet_r};
        REG_ANID: prdata_nxt = {18'h0_0000, anid_r};
        REG_TIME: prdata_nxt = {7'h00, day_r, 3'h0, hour_r, 2'h0, min_r};
        REG_STAT: prdata_nxt = {16'h0000, len_r, 2'h0, valid_r, tx_busy || msg_go_r,
                                drop_r, err_r, cmd_r, term_r};
        REG_CMD: prdata_nxt = {20'h0_0000, ntok_r, type_r};
        REG_ARGS: prdata_nxt = 32'(cls_r);
        REG_MSGC: prdata_nxt = {24'h00_0000, mlen_r};
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
    // Writes land on the edge where the master sees pready
    wr = psel && penable && pready_r && pwrite && hit;
    if (wr) begin
      case (paddr)
        REG_CTRL: begin
          quiet_nxt = pwdata[CTRL_QUIET];
          flag1_nxt = pwdata[CTRL_FLAG1];
          flag2_nxt = pwdata[CTRL_FLAG2];
          if (pwdata[CTRL_FLAG1] || pwdata[CTRL_FLAG2]) term_nxt = 1'b0; // R3
        end
        REG_ANID: anid_nxt = pwdata[13:0];
        REG_TIME: begin
          min_nxt = pwdata[TIME_MIN +: 6];
          hour_nxt = pwdata[TIME_HOUR +: 5];
          day_nxt = pwdata[TIME_DAY +: 9];
        end
        REG_STAT: begin
          // Write one to clear; a same-cycle event below wins
          if (pwdata[STAT_CMD]) cmd_nxt = 1'b0;
          if (pwdata[STAT_ERR]) err_nxt = 1'b0;
          if (pwdata[STAT_DROP]) drop_nxt = 1'b0;
        end
        REG_MSGD: begin
          if (tx_busy || msg_go_r || mlen_r == 8'(MSG_DEPTH)) begin
            err_nxt = 1'b1;
          end else begin
            msg_nxt[mlen_r[$clog2(MSG_DEPTH)-1:0]] = pwdata[7:0];
            mlen_nxt = mlen_r + 8'h01;
          end
        end
        REG_MSGC: begin
          if (tx_busy || msg_go_r || !is_type(pwdata[7:0])) begin
            err_nxt = 1'b1; // R21
          end else if (pwdata[MSGC_UNSOL] && quiet_r) begin
            drop_nxt = 1'b1; // R18
            mlen_nxt = 8'h00;
          end else begin
            mtype_nxt = pwdata[7:0];
            msg_go_nxt = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // Receive side: control characters and line editing
    if (take) begin
      case (rx_data)
        CH_CTRL_T: if (!flag1_r && !flag2_r) term_nxt = 1'b1; // R1 R3
        CH_CTRL_C: term_nxt = 1'b0; // R2
        CH_CTRL_P: help_go_nxt = 1'b1; // R8
        CH_ESC: len_nxt = 8'h00; // R6
        CH_BS: begin
          if (term_r && len_r != 8'h00) begin
            len_nxt = len_r - 8'h01; // R5
            echo_pend_nxt = 1'b1;
            echo_ch_nxt = rx_data;
          end
        end
        CH_CR: begin
          sc_nxt = SC_SCAN; // R4
          sidx_nxt = 8'h00;
          ntok_nxt = 4'h0;
          cls_nxt = '0;
          valid_nxt = 1'b0;
          type_nxt = 8'h00;
          id_arg_nxt = 14'h0000;
          in_quote_nxt = 1'b0;
          tk_nxt = '0;
          if (term_r) begin
            echo_pend_nxt = 1'b1;
            echo_ch_nxt = rx_data;
          end
        end
        default: begin
          // Buffer until the line ends; a full line ignores extra bytes
          if (len_r != 8'(LINE_DEPTH)) begin
            line_nxt[len_r[$clog2(LINE_DEPTH)-1:0]] = rx_data; // R4
            len_nxt = len_r + 8'h01;
          end
          if (term_r) begin
            echo_pend_nxt = 1'b1; // R1
            echo_ch_nxt = rx_data;
          end
        end
      endcase
    end
    // Scanner: one buffered character per cycle, spaces split tokens
    if (sc_r == SC_SCAN) begin
      tend = sidx_r == len_r;
      if (!tend) c = line_r[sidx_r[$clog2(LINE_DEPTH)-1:0]];
      delim = tend || (c == CH_SP && !in_quote_r); // R9
      if (delim) begin
        if (tk_r.len != 8'h00) begin
          tcls = classify(tk_r);
          if (ntok_r == 4'h0) begin
            type_nxt = upc(tk_r.word[23:16]); // R9
            valid_nxt = tk_r.len == 8'h01 && is_type(upc(tk_r.word[23:16])); // R10 R11
          end else if (ntok_r <= 4'(MAX_TOK)) begin
            cls_nxt[3*(ntok_r-4'h1) +: 3] = tcls;
          end
          if (ntok_r == 4'h1) id_arg_nxt = (tcls == CLS_INT) ? tk_r.val : 14'h3FFF;
          if (ntok_r != 4'hF) ntok_nxt = ntok_r + 4'h1;
        end
        tk_nxt = '0;
        tk_nxt.numok = 1'b1;
        tk_nxt.hexok = 1'b1;
        in_quote_nxt = 1'b0;
      end else begin
        // Token flags grow one character at a time
        if (tk_r.len == 8'h00 && c == CH_QUOTE) begin
          tk_nxt.quote = 1'b1;
          in_quote_nxt = 1'b1;
        end else if (tk_r.quote) begin
          if (tk_r.closed) tk_nxt.bad = 1'b1;
          else if (c == CH_QUOTE) tk_nxt.closed = 1'b1; // R16
          else if (c < CH_SP || c > 8'h7E) tk_nxt.bad = 1'b1;
          if (c == CH_QUOTE) in_quote_nxt = 1'b0;
        end
        if (tk_r.len == 8'h00 && (c == "+" || c == "-")) begin
          tk_nxt.numok = 1'b1; // R12 R14
        end else if (is_dig(c)) begin
          tk_nxt.digits = 1'b1;
          tk_nxt.val = 14'(tk_r.val * 14'd10 + 14'(c - 8'h30));
        end else if (c == ".") begin
          if (tk_r.dots != 2'h3) tk_nxt.dots = tk_r.dots + 2'h1;
        end else begin
          tk_nxt.numok = 1'b0; // R14
        end
        if (tk_r.len == 8'h00) begin
          tk_nxt.hexok = c == "0";
        end else if (tk_r.len == 8'h01) begin
          tk_nxt.hexok = tk_r.hexok && c == "x";
        end else begin
          tk_nxt.hexok = tk_r.hexok && (is_dig(c) || (upc(c) >= "A" && upc(c) <= "F")); // R13
        end
        if (tk_r.len < 8'h03) tk_nxt.word[8*(2-tk_r.len[1:0]) +: 8] = upc(c); // R9
        if (tk_r.len != 8'hFF) tk_nxt.len = tk_r.len + 8'h01;
      end
      if (tend) sc_nxt = SC_DONE;
      else sidx_nxt = sidx_r + 8'h01;
    end
    // Line done: help is served here, any other non-empty line not starting with ? goes to software
    if (sc_r == SC_DONE) begin
      help_ok = type_r == CH_QMARK && ntok_r != 4'h0 &&
                (ntok_r == 4'h1 || (ntok_r == 4'h2 && id_arg_r == anid_r)); // R7
      if (help_ok) help_go_nxt = 1'b1; // R7
      else if (ntok_r != 4'h0 && type_r != CH_QMARK) cmd_nxt = 1'b1; // R10
      len_nxt = 8'h00;
      sc_nxt = SC_IDLE;
    end
    if (msg_go_r) mlen_nxt = 8'h00;
    rx_ready_nxt = sc_nxt == SC_IDLE && !echo_pend_nxt && !(take && rx_data == CH_CR);
  end

  // Command side registers
  always_ff @(posedge clock) begin
    if (reset) begin
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      quiet_r <= 1'b0;
      flag1_r <= 1'b0;
      flag2_r <= 1'b0;
      anid_r <= ANID_RESET;
      day_r <= DAY_RESET;
      hour_r <= 5'h00;
      min_r <= 6'h00;
      term_r <= 1'b0;
      cmd_r <= 1'b0;
      err_r <= 1'b0;
      drop_r <= 1'b0;
      valid_r <= 1'b0;
      type_r <= 8'h00;
      ntok_r <= 4'h0;
      cls_r <= '0;
      len_r <= 8'h00;
      sidx_r <= 8'h00;
      mlen_r <= 8'h00;
      mtype_r <= 8'h00;
      rx_ready_r <= 1'b0;
      echo_pend_r <= 1'b0;
      echo_ch_r <= 8'h00;
      help_go_r <= 1'b0;
      msg_go_r <= 1'b0;
      in_quote_r <= 1'b0;
      id_arg_r <= 14'h0000;
      tk_r <= '0;
      sc_r <= SC_IDLE;
    end else begin
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      quiet_r <= quiet_nxt;
      flag1_r <= flag1_nxt;
      flag2_r <= flag2_nxt;
      anid_r <= anid_nxt;
      day_r <= day_nxt;
      hour_r <= hour_nxt;
      min_r <= min_nxt;
      term_r <= term_nxt;
      cmd_r <= cmd_nxt;
      err_r <= err_nxt;
      drop_r <= drop_nxt;
      valid_r <= valid_nxt;
      type_r <= type_nxt;
      ntok_r <= ntok_nxt;
      cls_r <= cls_nxt;
      len_r <= len_nxt;
      sidx_r <= sidx_nxt;
      mlen_r <= mlen_nxt;
      mtype_r <= mtype_nxt;
      rx_ready_r <= rx_ready_nxt;
      echo_pend_r <= echo_pend_nxt;
      echo_ch_r <= echo_ch_nxt;
      help_go_r <= help_go_nxt;
      msg_go_r <= msg_go_nxt;
      in_quote_r <= in_quote_nxt;
      id_arg_r <= id_arg_nxt;
      tk_r <= tk_nxt;
      sc_r <= sc_nxt;
    end
  end

  // Buffers carry no reset; their length counters guard every read
  always_ff @(posedge clock) begin
    line_r <= line_nxt;
    msg_r <= msg_nxt;
  end

  // ------------------------------------------------------------------
  // Transmitter: echo, help listing and formatted messages
  // ------------------------------------------------------------------
  // Echo only starts from idle so it never splits a message
  assign echo_take = echo_pend_r && tx_r == TX_IDLE && (!tx_valid_r || tx_ready) &&
                     !help_go_r && !msg_go_r;

  always_comb begin
    logic free, emit;
    logic [7:0] ch;
    free = !tx_valid_r || tx_ready;
    emit = 1'b0;
    ch = 8'h00;
    tx_nxt = tx_r;
    pos_nxt = pos_r;
    hpos_nxt = hpos_r;
    blen_nxt = blen_r;
    help_mode_nxt = help_mode_r;
    if (help_go_r) begin
      // Also restarts a listing already under way
      tx_nxt = TX_HELP; // R8
      pos_nxt = 8'h00;
      help_mode_nxt = 1'b1;
    end else if (msg_go_r) begin
      tx_nxt = TX_HEAD;
      hpos_nxt = 5'h00;
      pos_nxt = 8'h00;
      blen_nxt = mlen_r;
      help_mode_nxt = 1'b0;
    end else if (free) begin
      case (tx_r)
        TX_IDLE: begin
          emit = echo_pend_r; // R1
          ch = echo_ch_r;
        end
        TX_HEAD: begin
          emit = 1'b1;
          case (hpos_r)
            5'h00: ch = mtype_r; // R19 R21
            5'h02: ch = dec_ch(14'(day_r), 14'd100); // R23
            5'h03: ch = dec_ch(14'(day_r), 14'd10);
            5'h04: ch = dec_ch(14'(day_r), 14'd1);
            5'h05, 5'h08: ch = CH_COLON; // R19
            5'h06: ch = dec_ch(14'(hour_r), 14'd10);
            5'h07: ch = dec_ch(14'(hour_r), 14'd1);
            5'h09: ch = dec_ch(14'(min_r), 14'd10);
            5'h0A: ch = dec_ch(14'(min_r), 14'd1);
            // Id has no padding: leading zero places are skipped
            5'h0C: begin
              emit = anid_r >= 14'd1000; // R20
              ch = dec_ch(anid_r, 14'd1000);
            end
            5'h0D: begin
              emit = anid_r >= 14'd100;
              ch = dec_ch(anid_r, 14'd100);
            end
            5'h0E: begin
              emit = anid_r >= 14'd10;
              ch = dec_ch(anid_r, 14'd10);
            end
            5'h0F: ch = dec_ch(anid_r, 14'd1);
            default: ch = CH_SP;
          endcase
          hpos_nxt = hpos_r + 5'h01;
          if (hpos_r == HEAD_LAST) tx_nxt = (blen_r == 8'h00) ? TX_CR : TX_BODY;
        end
        TX_BODY: begin
          emit = 1'b1;
          ch = msg_r[pos_r[$clog2(MSG_DEPTH)-1:0]]; // R20
          pos_nxt = pos_r + 8'h01;
          if (pos_nxt == blen_r) tx_nxt = TX_CR;
        end
        TX_CR: begin
          emit = 1'b1;
          ch = CH_CR; // R22
          tx_nxt = TX_LF;
        end
        TX_LF: begin
          emit = 1'b1;
          ch = CH_LF; // R22
          tx_nxt = (help_mode_r && pos_r != 8'(HELP_LEN)) ? TX_HELP : TX_IDLE;
        end
        TX_HELP: begin
          ch = HELP_TEXT[8*(HELP_LEN-1-int'(pos_r)) +: 8]; // R7
          emit = ch != CH_BAR;
          pos_nxt = pos_r + 8'h01;
          if (ch == CH_BAR) tx_nxt = TX_CR;
        end
        default: tx_nxt = TX_IDLE;
      endcase
    end
    tx_valid_nxt = free ? emit : tx_valid_r;
    tx_data_nxt = (free && emit) ? ch : tx_data_r;
  end

  // Transmitter registers
  always_ff @(posedge clock) begin
    if (reset) begin
      tx_r <= TX_IDLE;
      tx_valid_r <= 1'b0;
      tx_data_r <= 8'h00;
      pos_r <= 8'h00;
      hpos_r <= 5'h00;
      blen_r <= 8'h00;
      help_mode_r <= 1'b0;
    end else begin
      tx_r <= tx_nxt;
      tx_valid_r <= tx_valid_nxt;
      tx_data_r <= tx_data_nxt;
      pos_r <= pos_nxt;
      hpos_r <= hpos_nxt;
      blen_r <= blen_nxt;
      help_mode_r <= help_mode_nxt;
    end
  end

endmodule : scli_core

// >>> scli_sva.sv
// Port checker for the command line interpreter
`timescale 1ns/10ps
module scli_sva (
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_ready
);
  import scli_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // Access phase still waiting for its answer
  sequence s_acc;
    psel && penable && !pready;
  endsequence
  sequence s_bad;
    paddr > REG_MSGC || paddr[1:0] != 2'b00;
  endsequence
  a_one_wait: assert property (s_acc |=> pready) else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_err_bad: assert property (s_acc ##0 s_bad |=> pslverr) else $error("no pslverr");
  a_ok_good: assert property (s_acc ##0 !s_bad |=> !pslverr) else $error("false pslverr");
  a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("bad error answer");
  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("tx byte dropped");
  a_cr_scan: assert property (rx_valid && rx_ready && rx_data == CH_CR |=> !rx_ready)
    else $error("rx open in scan");
  // Escape is swallowed, so no copy of it may leave soon after
  a_esc_silent: assert property (rx_valid && rx_ready && rx_data == CH_ESC
    |=> !(tx_valid && tx_data == CH_ESC) [*4]) else $error("escape echoed");
endmodule : scli_sva
bind scli_core scli_sva i_sva (.*);

// >>> scli_host.sv
// Host terminal model on the far side of the byte streams
`timescale 1ns/10ps
module scli_host (
  input wire logic clock,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic tx_ready
);
  logic [7:0] got [$];
  logic [7:0] lfsr = 8'h5a;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'hff;
    tx_ready = 1'b0;
  end
  // Random stalls, so held tx bytes get exercised
  always @(posedge clock) begin
    lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    tx_ready <= lfsr[0] | lfsr[1];
    if (tx_valid && tx_ready) got.push_back(tx_data);
  end
  // One byte; idle data line shows the inverse, not the last value
  task automatic send(input logic [7:0] b);
    @(posedge clock);
    rx_valid <= 1'b1;
    rx_data <= b;
    do @(posedge clock); while (rx_ready !== 1'b1);
    rx_valid <= 1'b0;
    rx_data <= ~b;
  endtask : send
endmodule : scli_host

// >>> scli_core_test.sv
// Self-checking bench for the command line interpreter
`timescale 1ns/10ps
module scli_core_test;
  import scli_pkg::*;
  logic clock = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic rx_valid, rx_ready, tx_valid, tx_ready;
  logic [7:0] paddr = 8'h00, rx_data, tx_data;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, id, dy, hr, mn;
  logic [31:0] seed = 32'h0000_d611;
  int errors = 0, n_tests = 0, cyc = 0;
  string s, t = "CDLTVW";
  always #5 clock = ~clock;
  scli_core i_dut (.*);
  scli_host i_host (.*);
  task automatic stop_test();
    if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  // Hang guard, far above the thousand or fewer cycles needed
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      stop_test();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // One APB transfer; no cycle count assumed for the answer
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    repeat (20) @(posedge clock);
    apb(1'b0, a, 32'h0000_0000);
    chk("reg", e, rd & m);
  endtask : rchk
  task automatic line(input string l);
    foreach (l[i]) i_host.send(l[i]);
  endtask : line
  initial begin
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    rchk(REG_TIME, 32'hffff_ffff, 32'h0001_0000);
    rchk(REG_STAT, 32'hffff_ffff, 32'h0000_0000);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk("pslverr", 1, err);
    i_host.send(CH_CTRL_T);
    i_host.send("A");
    rchk(REG_STAT, 32'h0000_ff01, 32'h0000_0101);
    chk("echo", "A", i_host.got[0]);
    i_host.send(CH_BS);
    rchk(REG_STAT, 32'h0000_ff01, 32'h0000_0001);
    i_host.send(CH_CTRL_C);
    rchk(REG_STAT, 32'h0000_0001, 32'h0000_0000);
    apb(1'b1, REG_CTRL, 32'h0000_0002);
    i_host.send(CH_CTRL_T);
    rchk(REG_STAT, 32'h0000_0001, 32'h0000_0000);
    apb(1'b1, REG_CTRL, 32'h0000_0000);
    line("t 12 0x1f ON");
    rchk(REG_STAT, 32'h0000_ff02, 32'h0000_0c00);
    i_host.send(CH_CR);
    rchk(REG_CMD, 32'h0000_0fff, 32'h0000_0454);
    rchk(REG_ARGS, 32'h00ff_ffff, 32'h0000_0111);
    line("v 1");
    i_host.send(CH_ESC);
    rchk(REG_STAT, 32'h0000_ff00, 32'h0000_0000);
    // Every type letter, with random id and stamp
    foreach (t[j]) begin
      seed = xs(seed);
      id = seed % 10000;
      dy = seed % 366 + 1;
      hr = (seed >> 9) % 24;
      mn = (seed >> 14) % 60;
      apb(1'b1, REG_ANID, id);
      apb(1'b1, REG_TIME, (dy << 16) | (hr << 8) | mn);
      apb(1'b1, REG_MSGD, "O");
      apb(1'b1, REG_MSGD, "K");
      i_host.got.delete();
      s = $sformatf("%c %03d:%02d:%02d %0d OK\r\n", t[j], dy, hr, mn, id);
      apb(1'b1, REG_MSGC, t[j]);
      repeat (3000) if (i_host.got.size() < s.len()) @(posedge clock);
      foreach (s[k]) chk("tx", s[k], i_host.got[k]);
    end
    apb(1'b1, REG_CTRL, 32'h0000_0001);
    apb(1'b1, REG_MSGC, 32'h0000_0157);
    rchk(REG_STAT, 32'h0000_0008, 32'h0000_0008);
    chk("quiet", s.len(), i_host.got.size());
    stop_test();
  end
endmodule : scli_core_test
